// *** hw/interrupt_and_time_base_unit.sv ***
// interrupt request logic with two time-base generators
// assumes synchronous pins and events, a sub clock given as a one-cycle tick,
// and a sequencer that acks the presented vector in the cycle it sees it
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "irq_tb_defs.svh"

module interrupt_and_time_base_unit (
	input wire logic clk_i, // 125 MHz system clock
	input wire logic reset_n_i, // synchronous, active low
	input wire irq_tb_pkg::reg_req_type reg_i, // register port request
	output logic [`ITB_DW-1:0] rdata_o, // read data, cycle after read
	input wire logic [3:0] ext_irq_pins_i, // external interrupt pins
	input wire logic [3:0] pull_high_sel_i, // pull-high selection
	output logic [3:0] pull_high_o, // pull-high drive enables
	input wire logic [1:0] comparator_out_i, // comparator outputs
	input wire logic conversion_done_i, // conversion finished pulse
	input wire logic sub_clock_tick_i, // one pulse per sub clock period
	input wire logic [`ITB_NMF*4-1:0] mf_src_evt_i, // grouped source events
	input wire logic stack_full_i, // sequencer stack full
	input wire logic ack_i, // sequencer takes presented vector
	output irq_tb_pkg::vector_req_type vec_o, // vector request to sequencer
	output logic irq_o // unmasked status interrupt
);
	localparam int NMF = `ITB_NMF;
	localparam int NSRC = `ITB_NSRC;

	function automatic logic edge_hit(input logic [1:0] mode, input logic cur, input logic prev);
		edge_hit = ((mode == irq_tb_pkg::EDGE_RISE) && cur && !prev)
			|| ((mode == irq_tb_pkg::EDGE_FALL) && !cur && prev)
			|| ((mode == irq_tb_pkg::EDGE_BOTH) && (cur != prev));
	endfunction

	function automatic logic [`ITB_TB_CNT_W-1:0] period_last(input logic [`ITB_TB_SEL_W-1:0] sel);
		logic [`ITB_TB_CNT_W:0] one;
		one = {{`ITB_TB_CNT_W{1'b0}}, 1'b1};
		period_last = `ITB_TB_CNT_W'((one << (`ITB_TB_BASE_EXP + 32'(sel))) - 1'b1);
	endfunction

	function automatic logic [3:0] prio(input logic [NSRC-1:0] p);
		prio = 4'h0;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (p[i]) begin
				prio = 4'(i);
			end
		end
	endfunction

	logic [3:0] pin_prev_r;
	logic [1:0] cmp_prev_r;
	logic gie_r;
	logic [`ITB_DW-1:0] edge_r;
	logic [`ITB_F0_W-1:0] flags0_r;
	logic [`ITB_F0_W-1:0] en0_r;
	logic [`ITB_F1_W-1:0] flags1_r;
	logic [`ITB_F1_W-1:0] en1_r;
	logic [`ITB_PSC_W-1:0] psc_r [2];
	logic tb_on_r [2];
	logic [`ITB_TB_SEL_W-1:0] tb_sel_r [2];
	logic [`ITB_TB_CNT_W-1:0] tb_cnt_r [2];
	logic [1:0] div4_r;
	logic [`ITB_DW-1:0] mf_r [NMF];
	logic [NMF-1:0] mf_qual_prev_r;
	logic [`ITB_DW-1:0] status_r;
	logic [`ITB_DW-1:0] mask_r;
	logic [`ITB_DW-1:0] rdata_r;

	// address decode
	wire wr_ctrl = reg_i.wr && (reg_i.addr == `ITB_OFS_CTRL);
	wire wr_edge = reg_i.wr && (reg_i.addr == `ITB_OFS_EDGE);
	wire wr_f0 = reg_i.wr && (reg_i.addr == `ITB_OFS_FLAGS0);
	wire wr_en0 = reg_i.wr && (reg_i.addr == `ITB_OFS_EN0);
	wire wr_f1 = reg_i.wr && (reg_i.addr == `ITB_OFS_FLAGS1);
	wire wr_en1 = reg_i.wr && (reg_i.addr == `ITB_OFS_EN1);
	wire wr_status = reg_i.wr && (reg_i.addr == `ITB_OFS_STATUS);
	wire wr_mask = reg_i.wr && (reg_i.addr == `ITB_OFS_MASK);
	wire [1:0] wr_psc = {reg_i.wr && (reg_i.addr == `ITB_OFS_PSC1), reg_i.wr && (reg_i.addr == `ITB_OFS_PSC0)};
	wire [1:0] wr_tb = {reg_i.wr && (reg_i.addr == `ITB_OFS_TB1), reg_i.wr && (reg_i.addr == `ITB_OFS_TB0)};
	wire [NMF-1:0] wr_mf;
	wire [`ITB_DW-1:0] mf_rd;

	// events
	wire [3:0] ext_hit;
	wire [1:0] cmp_chg = comparator_out_i ^ cmp_prev_r;
	wire [1:0] tb_tick;
	wire [1:0] tb_ovf;
	wire [`ITB_TB_CNT_W-1:0] tb_last [2];
	wire [`ITB_TB_CNT_W-1:0] tb_cnt_nxt [2];
	wire [NMF-1:0] mf_qual;
	wire [NMF-1:0] mf_rise = mf_qual & ~mf_qual_prev_r;

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : gen_ext
			assign ext_hit[g] = edge_hit(edge_r[2*g +: 2], ext_irq_pins_i[g], pin_prev_r[g]);
		end
		for (g = 0; g < 2; g++) begin : gen_tb
			// 1x selects the sub clock whatever the low bit holds
			assign tb_tick[g] = (psc_r[g] == `ITB_PSC_SYS) ? 1'b1 :
				(psc_r[g] == `ITB_PSC_DIV4) ? (div4_r == `ITB_DIV4_LAST) : sub_clock_tick_i;
			assign tb_last[g] = period_last(tb_sel_r[g]);
			// masking keeps a mid-count period change from running past the new end
			assign tb_ovf[g] = tb_on_r[g] && tb_tick[g] && ((tb_cnt_r[g] & tb_last[g]) == tb_last[g]);
			assign tb_cnt_nxt[g] = !tb_on_r[g] ? `ITB_RST_CNT :
				tb_tick[g] ? ((tb_cnt_r[g] + 1'b1) & tb_last[g]) : tb_cnt_r[g];
		end
		for (g = 0; g < NMF; g++) begin : gen_mf
			assign wr_mf[g] = reg_i.wr && (reg_i.addr == (`ITB_OFS_MF0 + 5'(g)));
			assign mf_qual[g] = |(mf_r[g][7:4] & mf_r[g][3:0]);
		end
	endgenerate

	assign mf_rd = (reg_i.addr >= `ITB_OFS_MF0 && reg_i.addr < `ITB_OFS_MF0 + 5'(NMF)) ?
		mf_r[3'(reg_i.addr - `ITB_OFS_MF0)] : `ITB_RST_BYTE;

	// request selection
	wire [NSRC-1:0] pending = {flags1_r & en1_r, flags0_r & en0_r};
	wire eligible = gie_r && !stack_full_i;
	wire [3:0] win_idx = prio(pending);
	assign vec_o.req = eligible && (|pending);
	assign vec_o.index = win_idx;
	wire taken = ack_i && vec_o.req;
	wire [NSRC-1:0] svc = taken ? (NSRC'(1) << win_idx) : '0;

	wire [`ITB_F0_W-1:0] hw_set0 = {conversion_done_i, cmp_chg, ext_hit};
	wire [`ITB_F1_W-1:0] hw_set1 = {mf_rise, tb_ovf};
	// hardware set wins over both software clear and service clear
	wire [`ITB_F0_W-1:0] flags0_nxt = ((wr_f0 ? reg_i.wdata[`ITB_F0_W-1:0] : flags0_r)
		& ~svc[`ITB_F0_W-1:0]) | hw_set0;
	wire [`ITB_F1_W-1:0] flags1_nxt = ((wr_f1 ? reg_i.wdata[`ITB_F1_W-1:0] : flags1_r)
		& ~svc[NSRC-1:`ITB_F0_W]) | hw_set1;
	// a software write of the enable in the ack cycle overrides the auto clear
	wire gie_nxt = wr_ctrl ? reg_i.wdata[0] : (taken ? 1'b0 : gie_r);

	wire [`ITB_DW-1:0] status_evt = {1'b0, taken, |mf_rise, tb_ovf, conversion_done_i, |cmp_chg, |ext_hit};
	wire [`ITB_DW-1:0] status_nxt = (status_r & ~(wr_status ? reg_i.wdata : `ITB_RST_BYTE)) | status_evt;

	wire [`ITB_DW-1:0] rd_val =
		(reg_i.addr == `ITB_OFS_CTRL) ? {7'h00, gie_r} :
		(reg_i.addr == `ITB_OFS_EDGE) ? edge_r :
		(reg_i.addr == `ITB_OFS_FLAGS0) ? {1'b0, flags0_r} :
		(reg_i.addr == `ITB_OFS_EN0) ? {1'b0, en0_r} :
		(reg_i.addr == `ITB_OFS_FLAGS1) ? {1'b0, flags1_r} :
		(reg_i.addr == `ITB_OFS_EN1) ? {1'b0, en1_r} :
		(reg_i.addr == `ITB_OFS_PSC0) ? {6'h00, psc_r[0]} :
		(reg_i.addr == `ITB_OFS_PSC1) ? {6'h00, psc_r[1]} :
		(reg_i.addr == `ITB_OFS_TB0) ? {tb_on_r[0], 4'h0, tb_sel_r[0]} :
		(reg_i.addr == `ITB_OFS_TB1) ? {tb_on_r[1], 4'h0, tb_sel_r[1]} :
		(reg_i.addr == `ITB_OFS_STATUS) ? status_r :
		(reg_i.addr == `ITB_OFS_MASK) ? mask_r : mf_rd;

	// pull-high stays whatever software selected, interrupt use or not
	assign pull_high_o = pull_high_sel_i;
	assign irq_o = |(status_r & mask_r);
	assign rdata_o = rdata_r;

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			pin_prev_r <= 4'h0;
			cmp_prev_r <= 2'h0;
			gie_r <= 1'b0;
			edge_r <= `ITB_RST_BYTE;
			flags0_r <= '0;
			en0_r <= '0;
			flags1_r <= '0;
			en1_r <= '0;
			status_r <= `ITB_RST_BYTE;
			mask_r <= `ITB_RST_BYTE;
			rdata_r <= `ITB_RST_BYTE;
			div4_r <= 2'h0;
			mf_qual_prev_r <= '0;
		end else begin
			pin_prev_r <= ext_irq_pins_i;
			cmp_prev_r <= comparator_out_i;
			gie_r <= gie_nxt;
			edge_r <= wr_edge ? reg_i.wdata : edge_r;
			flags0_r <= flags0_nxt;
			en0_r <= wr_en0 ? reg_i.wdata[`ITB_F0_W-1:0] : en0_r;
			flags1_r <= flags1_nxt;
			en1_r <= wr_en1 ? reg_i.wdata[`ITB_F1_W-1:0] : en1_r;
			status_r <= status_nxt;
			mask_r <= wr_mask ? reg_i.wdata : mask_r;
			rdata_r <= reg_i.rd ? rd_val : `ITB_RST_BYTE;
			div4_r <= div4_r + 2'h1;
			mf_qual_prev_r <= mf_qual;
		end
	end

	always_ff @(posedge clk_i) begin
		for (int k = 0; k < 2; k++) begin
			if (!reset_n_i) begin
				psc_r[k] <= `ITB_RST_PSC;
				tb_on_r[k] <= 1'b0;
				tb_sel_r[k] <= `ITB_RST_SEL;
				tb_cnt_r[k] <= `ITB_RST_CNT;
			end else begin
				psc_r[k] <= wr_psc[k] ? reg_i.wdata[`ITB_PSC_W-1:0] : psc_r[k];
				tb_on_r[k] <= wr_tb[k] ? reg_i.wdata[`ITB_TB_ON_BIT] : tb_on_r[k];
				tb_sel_r[k] <= wr_tb[k] ? reg_i.wdata[`ITB_TB_SEL_W-1:0] : tb_sel_r[k];
				tb_cnt_r[k] <= tb_cnt_nxt[k];
			end
		end
	end

	// grouped source flags: set by events, cleared only by software
	always_ff @(posedge clk_i) begin
		for (int m = 0; m < NMF; m++) begin
			if (!reset_n_i) begin
				mf_r[m] <= `ITB_RST_BYTE;
			end else begin
				mf_r[m][7:4] <= (wr_mf[m] ? reg_i.wdata[7:4] : mf_r[m][7:4]) | mf_src_evt_i[4*m +: 4];
				mf_r[m][3:0] <= wr_mf[m] ? reg_i.wdata[3:0] : mf_r[m][3:0];
			end
		end
	end

	a_ext_edge_flag: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		ext_hit[0] |=> flags0_r[0])
		else $error("edge did not set pin flag");
	a_vector_gating: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		vec_o.req |-> gie_r && !stack_full_i && (|pending))
		else $error("vector without enables");
	a_service_gie: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		taken && !wr_ctrl |=> !gie_r && !vec_o.req)
		else $error("service left global enable set");
	a_ext_flag_clear: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		taken && win_idx == `ITB_SRC_EXT0 && !ext_hit[0] && !wr_f0 |=> !flags0_r[0])
		else $error("pin flag not cleared by service");
	a_edge_off_quiet: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		edge_r[1:0] == irq_tb_pkg::EDGE_OFF |-> !ext_hit[0])
		else $error("disabled pin triggered");
	a_pullup_kept: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		pull_high_o == pull_high_sel_i)
		else $error("pull-high altered");
	a_cmp_change: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		$changed(comparator_out_i[1]) |-> ##1 flags0_r[5])
		else $error("comparator change lost");
	a_mf_src_kept: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		taken && win_idx == `ITB_SRC_MF0 && mf_r[0][4] && !wr_mf[0] |=> mf_r[0][4])
		else $error("grouped flag cleared by service");
	a_tb_spacing: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		tb_ovf[0] |=> !tb_ovf[0] [*8])
		else $error("tick overflow too soon");
	a_tb_off_idle: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		!tb_on_r[1] |=> tb_cnt_r[1] == `ITB_RST_CNT && !tb_ovf[1])
		else $error("generator ran while off");
	a_rsvd_zero: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		reg_i.rd && reg_i.addr == `ITB_OFS_TB0 |=> rdata_o[6:3] == 4'h0)
		else $error("reserved bits set");
	a_fixed_prio: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		vec_o.req && pending[0] |-> vec_o.index == 4'h0)
		else $error("priority order broken");

	// per-pin edge checks; pin 0 alone would miss a swapped mode field
	generate
		for (g = 0; g < 4; g++) begin : gen_pin_chk
			a_pin_flag_set: assert property (@(posedge clk_i) disable iff (!reset_n_i)
				ext_hit[g] |=> flags0_r[g])
				else $error("pin edge lost");
			a_pin_off_quiet: assert property (@(posedge clk_i) disable iff (!reset_n_i)
				edge_r[2*g +: 2] == irq_tb_pkg::EDGE_OFF |-> !ext_hit[g])
				else $error("pin off but triggered");
			a_pin_rise_seen: assert property (@(posedge clk_i) disable iff (!reset_n_i)
				edge_r[2*g +: 2] == irq_tb_pkg::EDGE_RISE && ext_irq_pins_i[g] && !pin_prev_r[g] |-> ext_hit[g])
				else $error("rising edge missed");
			a_pin_fall_seen: assert property (@(posedge clk_i) disable iff (!reset_n_i)
				edge_r[2*g +: 2] == irq_tb_pkg::EDGE_FALL && !ext_irq_pins_i[g] && pin_prev_r[g] |-> ext_hit[g])
				else $error("falling edge missed");
			a_pin_both_seen: assert property (@(posedge clk_i) disable iff (!reset_n_i)
				edge_r[2*g +: 2] == irq_tb_pkg::EDGE_BOTH && ext_irq_pins_i[g] != pin_prev_r[g] |-> ext_hit[g])
				else $error("pin change missed");
		end
	endgenerate

	// flag set and service clear per source kind; a same-cycle event is excluded since set wins
	a_cmp_flag_set: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		cmp_chg[0] |=> flags0_r[4])
		else $error("comparator 0 change lost");
	a_cmp1_flag_set: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		cmp_chg[1] |=> flags0_r[5])
		else $error("comparator 1 change lost");
	a_cmp_flag_clear: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		taken && win_idx == `ITB_SRC_CMP0 && !cmp_chg[0] && !wr_f0 |=> !flags0_r[4])
		else $error("comparator flag not cleared");
	a_conv_flag_set: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		conversion_done_i |=> flags0_r[6])
		else $error("conversion done lost");
	a_conv_flag_clear: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		taken && win_idx == `ITB_SRC_CONV && !conversion_done_i && !wr_f0 |=> !flags0_r[6])
		else $error("conversion flag not cleared");
	a_tick_flag_set: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		tb_ovf[0] |=> flags1_r[0])
		else $error("tick 0 overflow lost");
	a_tick1_flag_set: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		tb_ovf[1] |=> flags1_r[1])
		else $error("tick 1 overflow lost");
	a_tick_flag_clear: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		taken && win_idx == `ITB_SRC_TB0 && !tb_ovf[0] && !wr_f1 |=> !flags1_r[0])
		else $error("tick flag not cleared");
	a_mf_flag_set: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		mf_rise[0] |=> flags1_r[2])
		else $error("aggregate flag not set");
	a_mf_flag_clear: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		taken && win_idx == `ITB_SRC_MF0 && !mf_rise[0] && !wr_f1 |=> !flags1_r[2])
		else $error("aggregate flag not cleared");
	a_mf_src_set: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		mf_src_evt_i[0] |=> mf_r[0][4])
		else $error("grouped source event lost");
	a_mf_needs_enable: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		!(|mf_r[0][3:0]) |-> !mf_rise[0])
		else $error("aggregate rose with no source enable");

	a_full_blocks: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		stack_full_i |-> !vec_o.req)
		else $error("vector with full stack");
	a_gie_blocks: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		!gie_r |-> !vec_o.req)
		else $error("vector with global enable off");
	a_pin_vec_enabled: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		vec_o.req && vec_o.index == `ITB_SRC_EXT0 |-> en0_r[0] && flags0_r[0])
		else $error("pin vector without flag and enable");

	// counter stepping is checked only inside the period, so a shortened period may wrap early
	a_sys_tick_count: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		tb_on_r[0] && psc_r[0] == `ITB_PSC_SYS && !wr_tb[0] && tb_cnt_r[0] < tb_last[0]
		|=> tb_cnt_r[0] == `ITB_TB_CNT_W'($past(tb_cnt_r[0]) + 1'b1))
		else $error("system clock tick not counted");
	a_sub_tick_hold: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		tb_on_r[0] && psc_r[0][`ITB_PSC_SUB_BIT] && !sub_clock_tick_i && !wr_tb[0] |=> $stable(tb_cnt_r[0]))
		else $error("counted without sub clock tick");
	a_period_wrap: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		tb_ovf[0] && !wr_tb[0] |=> tb_cnt_r[0] == `ITB_RST_CNT)
		else $error("counter did not wrap at overflow");
	a_psc_rsvd_zero: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		reg_i.rd && reg_i.addr == `ITB_OFS_PSC0 |=> rdata_o[7:2] == 6'h00)
		else $error("prescaler reserved bits set");

	a_status_sticky: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		status_r[3] && !(wr_status && reg_i.wdata[3]) |=> status_r[3])
		else $error("status bit lost without clear");
	a_rdata_idle: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		!reg_i.rd |=> rdata_o == `ITB_RST_BYTE)
		else $error("read data outside read cycle");
	a_irq_masked: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		mask_r == `ITB_RST_BYTE |-> !irq_o)
		else $error("interrupt with all masked");

	c_ext_service: cover property (@(posedge clk_i) disable iff (!reset_n_i)
		ext_hit[0] ##[1:20] (taken && win_idx == `ITB_SRC_EXT0));
	c_tb_overflow: cover property (@(posedge clk_i) disable iff (!reset_n_i) tb_ovf[0]);
	c_mf_service: cover property (@(posedge clk_i) disable iff (!reset_n_i)
		mf_rise[0] ##[1:20] (taken && win_idx == `ITB_SRC_MF0));
	c_cmp_service: cover property (@(posedge clk_i) disable iff (!reset_n_i)
		cmp_chg[0] ##[1:20] (taken && win_idx == `ITB_SRC_CMP0));
	c_stack_hold: cover property (@(posedge clk_i) disable iff (!reset_n_i)
		gie_r && (|pending) && stack_full_i);
endmodule
`default_nettype wire

// *** hw/irq_tb_defs.svh ***
// constants of the interrupt and time base unit: register map, fields, resets
// assumes an 8-bit register port with a 5-bit word address
`ifndef IRQ_TB_DEFS_SVH
`define IRQ_TB_DEFS_SVH
`define ITB_AW 5
`define ITB_DW 8
`define ITB_OFS_CTRL 5'h00
`define ITB_OFS_EDGE 5'h01
`define ITB_OFS_FLAGS0 5'h02
`define ITB_OFS_EN0 5'h03
`define ITB_OFS_FLAGS1 5'h04
`define ITB_OFS_EN1 5'h05
`define ITB_OFS_PSC0 5'h06
`define ITB_OFS_PSC1 5'h07
`define ITB_OFS_TB0 5'h08
`define ITB_OFS_TB1 5'h09
`define ITB_OFS_MF0 5'h0a
`define ITB_OFS_STATUS 5'h0f
`define ITB_OFS_MASK 5'h10
`define ITB_NMF 5
`define ITB_NSRC 14
`define ITB_SRC_EXT0 4'h0
`define ITB_SRC_MF0 4'h9
`define ITB_SRC_CMP0 4'h4
`define ITB_SRC_CONV 4'h6
`define ITB_SRC_TB0 4'h7
`define ITB_PSC_SUB_BIT 1
`define ITB_F0_W 7
`define ITB_F1_W 7
`define ITB_TB_ON_BIT 7
`define ITB_TB_SEL_W 3
`define ITB_PSC_W 2
`define ITB_TB_CNT_W 15
`define ITB_TB_BASE_EXP 8
`define ITB_PSC_SYS 2'h0
`define ITB_PSC_DIV4 2'h1
`define ITB_DIV4_LAST 2'h3
`define ITB_RST_BYTE 8'h00
`define ITB_RST_PSC 2'h0
`define ITB_RST_SEL 3'h0
`define ITB_RST_CNT 15'h0000
`endif

// *** hw/irq_tb_pkg.sv ***
// types shared by the interrupt and time base unit and its users
// assumes the constants header is compiled alongside
package irq_tb_pkg;
	typedef enum logic [1:0] {
		EDGE_OFF = 2'b00,
		EDGE_RISE = 2'b01,
		EDGE_FALL = 2'b10,
		EDGE_BOTH = 2'b11
	} edge_mode_type;

	typedef struct packed {
		logic req;
		logic [3:0] index;
	} vector_req_type;

	typedef struct packed {
		logic [4:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_type;
endpackage

// *** test/interrupt_and_time_base_unit_test.sv ***
// self-checking bench of the interrupt and time base unit
// assumes the sequencer model answers for the cpu side
`timescale 1ns/10ps
`default_nettype none
module interrupt_and_time_base_unit_test;
	logic clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	irq_tb_pkg::reg_req_type reg_q = '0;
	irq_tb_pkg::vector_req_type vec;
	logic [3:0] pins = 4'h0;
	logic [3:0] pull_sel = 4'h0;
	logic [1:0] comp = 2'h0;
	logic [1:0] sub_div = 2'h0;
	logic [19:0] mf_evt = '0;
	logic conv = 1'b0;
	logic sub_tick = 1'b0;
	logic go = 1'b0;
	logic full = 1'b0;
	logic stack_full, ack, irq;
	logic [3:0] pull_high, taken;
	logic [7:0] rdata, count;
	int fail_count = 0;
	int checked = 0;
	int n;
	logic [4:0] ra [6] = '{5'h06, 5'h07, 5'h08, 5'h09, 5'h1f, 5'h01};
	logic [7:0] rexp [6] = '{8'h03, 8'h03, 8'h87, 8'h87, 8'h00, 8'hff};
	logic [7:0] tpsc [5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h00};
	logic [7:0] tsel [5] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h07};
	int tcyc [5] = '{256, 1024, 1536, 768, 32768};

	always #4 clk_i = ~clk_i;
	// sub clock as one tick every third cycle, unrelated to the divide-by-four phase
	always @(posedge clk_i) begin
		sub_div <= (sub_div == 2'h2) ? 2'h0 : sub_div + 2'h1;
		sub_tick <= (sub_div == 2'h2);
	end

	interrupt_and_time_base_unit DUT (
		.clk_i(clk_i), .reset_n_i(reset_n_i), .reg_i(reg_q), .rdata_o(rdata),
		.ext_irq_pins_i(pins), .pull_high_sel_i(pull_sel), .pull_high_o(pull_high),
		.comparator_out_i(comp), .conversion_done_i(conv), .sub_clock_tick_i(sub_tick),
		.mf_src_evt_i(mf_evt), .stack_full_i(stack_full), .ack_i(ack), .vec_o(vec), .irq_o(irq)
	);
	sequencer_model cpu (
		.clk_i(clk_i), .reset_n_i(reset_n_i), .vec_i(vec), .go_i(go), .full_i(full),
		.stack_full_o(stack_full), .ack_o(ack), .taken_o(taken), .count_o(count)
	);

	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("FAIL %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk_i) reg_q <= '{a, d, 1'b1, 1'b0};
		@(posedge clk_i) reg_q <= '0;
	endtask
	task automatic rd_chk(input string name, input logic [4:0] a, input logic [7:0] exp);
		@(posedge clk_i) reg_q <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk_i) reg_q <= '0;
		#1 chk(name, exp, rdata);
	endtask
	task automatic take(input logic [3:0] idx);
		logic [7:0] c0;
		c0 = count;
		n = 0;
		while (count === c0 && n < 50) begin
			@(posedge clk_i);
			#1 n++;
		end
		chk("vector count", c0 + 8'h01, count);
		chk("vector taken", {4'h0, idx}, {4'h0, taken});
	endtask
	task automatic end_of_test;
		if (fail_count == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		repeat (90000) @(posedge clk_i);
		fail_count++;
		end_of_test;
	end

	initial begin
		repeat (3) @(posedge clk_i);
		reset_n_i <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			rd_chk("reset value", ra[i], 8'h00);
			wr(ra[i], 8'hff);
			rd_chk("readback", ra[i], rexp[i]);
			wr(ra[i], 8'h00);
		end
		for (int m = 0; m < 4; m++) begin
			wr(5'h01, 8'(m));
			@(posedge clk_i) pins <= 4'h1;
			rd_chk("rise flag", 5'h02, {7'h0, m[0]});
			wr(5'h02, 8'h00);
			@(posedge clk_i) pins <= 4'h0;
			rd_chk("fall flag", 5'h02, {7'h0, m[1]});
			wr(5'h02, 8'h00);
		end
		wr(5'h10, 8'h08);
		for (int i = 0; i < 5; i++) begin
			wr(5'h08, 8'h00);
			wr(5'h0f, 8'hff);
			wr(5'h06, tpsc[i]);
			wr(5'h08, 8'h80 | tsel[i]);
			n = 0;
			while (irq !== 1'b1 && n < 40000) begin
				@(posedge clk_i);
				#1 n++;
			end
			chk("tick period", 8'h01, 8'(n >= tcyc[i] - 4 && n <= tcyc[i] + 4));
		end
		rd_chk("tick flag", 5'h04, 8'h01);
		wr(5'h08, 8'h00);
		#1 chk("irq unmasked", 8'h01, {7'h0, irq});
		wr(5'h10, 8'h00);
		#1 chk("irq masked", 8'h00, {7'h0, irq});
		wr(5'h10, 8'h08);
		#1 chk("irq remasked", 8'h01, {7'h0, irq});
		wr(5'h0f, 8'h08);
		#1 chk("irq cleared", 8'h00, {7'h0, irq});
		@(posedge clk_i) go <= 1'b1;
		wr(5'h05, 8'h01);
		wr(5'h00, 8'h01);
		take(4'h7);
		rd_chk("tick flag cleared", 5'h04, 8'h00);
		rd_chk("enable cleared", 5'h00, 8'h00);
		wr(5'h05, 8'h04);
		@(posedge clk_i) go <= 1'b0;
		full <= 1'b1;
		wr(5'h01, 8'h05);
		wr(5'h03, 8'h53);
		wr(5'h00, 8'h01);
		@(posedge clk_i) pins <= 4'h3;
		repeat (2) @(posedge clk_i);
		#1 chk("req stack full", 8'h00, {7'h0, vec.req});
		@(posedge clk_i) full <= 1'b0;
		#1 chk("winner", 8'h10, {3'h0, vec});
		@(posedge clk_i) go <= 1'b1;
		take(4'h0);
		rd_chk("pin flags", 5'h02, 8'h02);
		rd_chk("enable cleared", 5'h00, 8'h00);
		wr(5'h00, 8'h01);
		take(4'h1);
		@(posedge clk_i) comp <= 2'h1;
		wr(5'h00, 8'h01);
		take(4'h4);
		@(posedge clk_i) conv <= 1'b1;
		@(posedge clk_i) conv <= 1'b0;
		wr(5'h00, 8'h01);
		take(4'h6);
		rd_chk("flags cleared", 5'h02, 8'h00);
		@(posedge clk_i) comp <= 2'h3;
		rd_chk("cmp1 flag", 5'h02, 8'h20);
		wr(5'h02, 8'h00);
		wr(5'h0a, 8'h01);
		wr(5'h00, 8'h01);
		@(posedge clk_i) mf_evt <= 20'h00002;
		@(posedge clk_i) mf_evt <= 20'h00000;
		repeat (2) @(posedge clk_i);
		#1 chk("req unqualified", 8'h00, {7'h0, vec.req});
		rd_chk("group flags", 5'h0a, 8'h21);
		@(posedge clk_i) mf_evt <= 20'h00001;
		@(posedge clk_i) mf_evt <= 20'h00000;
		take(4'h9);
		rd_chk("sources kept", 5'h0a, 8'h31);
		rd_chk("aggregate cleared", 5'h04, 8'h00);
		wr(5'h0a, 8'h01);
		@(posedge clk_i) pull_sel <= 4'ha;
		#1 chk("pull high", 8'h0a, {4'h0, pull_high});
		@(posedge clk_i) reset_n_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		#1 chk("req in reset", 8'h00, {7'h0, vec.req});
		@(posedge clk_i) reset_n_i <= 1'b1;
		rd_chk("tick ctrl reset", 5'h08, 8'h00);
		rd_chk("edge reset", 5'h01, 8'h00);
		end_of_test;
	end
endmodule
`default_nettype wire

// *** test/sequencer_model.sv ***
// cpu sequencer stand-in: takes a presented vector when allowed and records it
// assumes vec_i is combinational from the unit; go_i and full_i come from the bench
`timescale 1ns/10ps
`default_nettype none
module sequencer_model (
	input wire logic clk_i, // system clock
	input wire logic reset_n_i, // synchronous, active low
	input wire irq_tb_pkg::vector_req_type vec_i, // presented vector
	input wire logic go_i, // high answers at once, low stalls
	input wire logic full_i, // stack full condition to present
	output logic stack_full_o, // stack full to the unit
	output logic ack_o, // vector taken this cycle
	output logic [3:0] taken_o, // last vector index taken
	output logic [7:0] count_o // vectors taken so far
);
	assign stack_full_o = full_i;
	// a full stack never acks, so a unit that ignores stack_full_i leaves the same flags and is caught only by a direct req check
	assign ack_o = vec_i.req & go_i & ~full_i;
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			taken_o <= 4'h0;
			count_o <= 8'h00;
		end else if (ack_o) begin
			taken_o <= vec_i.index;
			count_o <= count_o + 8'h01;
		end
	end
endmodule
`default_nettype wire
